// ===== design/fcd_pkg.sv
// package: flash command controller constants
package fcd_pkg;
    // command bytes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BUF_PROGRAM = 8'hE8;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    // status word bits
    localparam int SW_READY = 7;
    localparam int SW_ERASE_SUSP = 6;
    localparam int SW_ERASE_ERR = 5;
    localparam int SW_PROG_ERR = 4;
    localparam int SW_PROG_SUSP = 2;
    localparam logic [15:0] SW_RESET_VAL = 16'h0080;
    localparam int BUF_MAX_WORDS = 512;
    // own register map, byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // ctrl: [0] go write, [1] go read, [2] reset_powerdown (1 = assert)
    localparam int CTRL_WR = 0;
    localparam int CTRL_RD = 1;
    localparam int CTRL_RST = 2;
    // pin timing, ns, at 100 ns clock
    localparam int CLK_NS = 100;
    localparam int T_STROBE_NS = 100;
    localparam int T_ACCESS_NS = 200;
    localparam int T_STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== design/fcd_pin_if.sv
// interface: request/answer path between register front and pin engine
`timescale 1ns/100ps
interface fcd_pin_if;
    logic req_wr;
    logic req_rd;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic busy;
    logic done;
    logic [15:0] rdata;
    modport front (output req_wr, output req_rd, output addr, output wdata,
        input busy, input done, input rdata);
    modport engine (input req_wr, input req_rd, input addr, input wdata,
        output busy, output done, output rdata);
endinterface

// ===== design/fcd_pin_engine.sv
// module: one flash bus cycle on the pins, write or read
`timescale 1ns/100ps
module fcd_pin_engine (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request side
    fcd_pin_if.engine pif,
    // flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [23:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe
);
    typedef enum logic [3:0] {
        PE_IDLE = 4'b0001,
        PE_WSTB = 4'b0010,
        PE_RSTB = 4'b0100,
        PE_END = 4'b1000
    } fcd_pe_t;
    fcd_pe_t state_ff;
    logic [7:0] cnt_ff;
    logic [15:0] rdata_ff;
    logic done_ff;

    assign pif.busy = (state_ff != PE_IDLE);
    assign pif.done = done_ff;
    assign pif.rdata = rdata_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= PE_IDLE;
            cnt_ff <= 8'h00;
            done_ff <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_addr <= 24'h00_0000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe <= 1'b0;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                PE_IDLE:
                begin
                    // each access toggles chip select, so status refreshes
                    if (pif.req_wr)
                    begin
                        flash_addr <= pif.addr;
                        flash_dq_out <= pif.wdata;
                        flash_dq_oe <= 1'b1;
                        flash_ce_n <= 1'b0;
                        flash_we_n <= 1'b0;
                        cnt_ff <= 8'(fcd_pkg::T_STROBE_CYC);
                        state_ff <= PE_WSTB;
                    end
                    else if (pif.req_rd)
                    begin
                        flash_addr <= pif.addr;
                        flash_ce_n <= 1'b0;
                        flash_oe_n <= 1'b0;
                        cnt_ff <= 8'(fcd_pkg::T_ACCESS_CYC);
                        state_ff <= PE_RSTB;
                    end
                end
                PE_WSTB:
                begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01)
                    begin
                        // data held while we_n rises: device latches here
                        flash_we_n <= 1'b1;
                        state_ff <= PE_END;
                    end
                end
                PE_RSTB:
                begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01)
                    begin
                        rdata_ff <= flash_dq_in;
                        flash_oe_n <= 1'b1;
                        state_ff <= PE_END;
                    end
                end
                PE_END:
                begin
                    flash_ce_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= PE_IDLE;
                end
                default:
                begin
                    state_ff <= PE_IDLE;
                end
            endcase
        end
    end

    // a write never drives dq and oe together
    chk_no_contention: assert property (@(posedge hclk) disable iff (!hresetn)
        !(flash_dq_oe && !flash_oe_n)) else $error("dq driven during read");
    sequence s_we_low;
        !flash_we_n && !flash_ce_n;
    endsequence
    chk_we_latch_order: assert property (@(posedge hclk) disable iff (!hresetn)
        s_we_low ##1 flash_we_n |-> !flash_ce_n && flash_dq_oe)
        else $error("ce released before we rose");
    chk_read_done: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(flash_oe_n) |-> ##[1:8] done_ff) else $error("read never done");
endmodule // fcd_pin_engine

// ===== design/fcd_host.sv
// module: host-side flash command controller with AHB-Lite register slave
`timescale 1ns/100ps
// Contract
// - 0x40 then one write of address and data programs one word.
// - chip select or output enable must toggle for status to refresh.
// - after programming, write array read before reading array data.
// - 0xE8 opens buffered program of at most 512 words.
// - confirm 0xD0 after buffer loading starts the array write.
module fcd_host (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [23:0] flash_addr,
    input wire logic [15:0] flash_dq_in,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic reset_powerdown_n
);
    typedef enum logic [2:0] {
        MD_ARRAY = 3'b001,
        MD_STATUS = 3'b010,
        MD_OTHER = 3'b100
    } fcd_mode_t;

    fcd_pin_if pif ();
    logic [23:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic rst_ff;
    logic req_wr_ff;
    logic req_rd_ff;
    logic pend_ff;
    logic wr_ph_ff;
    logic [3:0] off_ff;
    fcd_mode_t mode_ff;
    logic setup_ff;
    logic [9:0] words_ff;
    logic buf_err_ff;
    logic [7:0] cmd;

    ////////////////////////////////////////////////////////////////////////////
    // ahb slave: zero wait except ctrl writes while a pin cycle runs
    assign hresp = 1'b0;
    assign hreadyout = !(wr_ph_ff && off_ff == fcd_pkg::REG_CTRL && pend_ff);
    wire addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_ff <= 1'b0;
            off_ff <= 4'h0;
        end
        else if (hreadyout)
        begin
            wr_ph_ff <= addr_ok && hwrite;
            off_ff <= haddr[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
        begin
            case (haddr[3:0])
                fcd_pkg::REG_ADDR: hrdata <= {8'h00, addr_ff};
                fcd_pkg::REG_WDATA: hrdata <= {16'h0000, wdata_ff};
                fcd_pkg::REG_STAT: hrdata <= {rdata_ff, 3'b000, buf_err_ff, 1'b0,
                    setup_ff, mode_ff != MD_ARRAY, pend_ff, 8'h00};
                default: hrdata <= {29'h0000_0000, rst_ff, 2'b00};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand registers and go bits
    wire ctrl_wr = wr_ph_ff && hreadyout && off_ff == fcd_pkg::REG_CTRL;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_ff <= 24'h00_0000;
            wdata_ff <= 16'h0000;
            rst_ff <= 1'b0;
        end
        else if (wr_ph_ff)
        begin
            if (off_ff == fcd_pkg::REG_ADDR)
                addr_ff <= hwdata[23:0];
            if (off_ff == fcd_pkg::REG_WDATA)
                wdata_ff <= hwdata[15:0];
            // holding reset_powerdown ends suspend and aborts work
            if (ctrl_wr)
                rst_ff <= hwdata[fcd_pkg::CTRL_RST];
        end
    end
    assign reset_powerdown_n = !rst_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_wr_ff <= 1'b0;
            req_rd_ff <= 1'b0;
            pend_ff <= 1'b0;
        end
        else
        begin
            req_wr_ff <= 1'b0;
            req_rd_ff <= 1'b0;
            if (ctrl_wr && !rst_ff && !hwdata[fcd_pkg::CTRL_RST])
            begin
                req_wr_ff <= hwdata[fcd_pkg::CTRL_WR];
                req_rd_ff <= hwdata[fcd_pkg::CTRL_RD] && !hwdata[fcd_pkg::CTRL_WR];
                pend_ff <= hwdata[fcd_pkg::CTRL_WR] | hwdata[fcd_pkg::CTRL_RD];
            end
            else if (pif.done)
                pend_ff <= 1'b0;
        end
    end

    assign pif.req_wr = req_wr_ff;
    assign pif.req_rd = req_rd_ff;
    // any address serves, command port has no location
    assign pif.addr = addr_ff;
    assign pif.wdata = wdata_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= 16'h0000;
        else if (pif.done && !pif.busy)
            rdata_ff <= pif.rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the device's read mode, for software's benefit
    assign cmd = wdata_ff[7:0];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_ff <= MD_ARRAY;
            setup_ff <= 1'b0;
            words_ff <= 10'h000;
            buf_err_ff <= 1'b0;
        end
        else if (rst_ff)
        begin
            mode_ff <= MD_ARRAY;
            setup_ff <= 1'b0;
            words_ff <= 10'h000;
        end
        else if (req_wr_ff)
        begin
            if (setup_ff)
            begin
                // second cycle: data/confirm, device answers with status
                setup_ff <= 1'b0;
                mode_ff <= MD_STATUS;
            end
            else if (words_ff != 10'h000)
            begin
                words_ff <= words_ff - 10'h001;
                if (words_ff == 10'h001)
                    setup_ff <= 1'b1; // next write is confirm
            end
            else
            begin
                case (cmd)
                    fcd_pkg::CMD_READ_ARRAY: mode_ff <= MD_ARRAY;
                    fcd_pkg::CMD_READ_STATUS: mode_ff <= MD_STATUS;
                    fcd_pkg::CMD_READ_ID: mode_ff <= MD_OTHER;
                    fcd_pkg::CMD_READ_QUERY: mode_ff <= MD_OTHER;
                    fcd_pkg::CMD_CLEAR_STATUS: buf_err_ff <= 1'b0;
                    fcd_pkg::CMD_PROGRAM, fcd_pkg::CMD_ERASE:
                    begin
                        setup_ff <= 1'b1;
                        mode_ff <= MD_STATUS;
                    end
                    // suspend and resume need no shadow step
                    default: mode_ff <= mode_ff;
                endcase
            end
        end
        else if (ctrl_wr && hwdata[fcd_pkg::CTRL_WR] && hwdata[15:6] != 10'h000)
        begin
            // word count in ctrl[15:6] arms a buffered load; a count above buffer size sets buf_err_ff instead
            if (hwdata[15:6] > 10'(fcd_pkg::BUF_MAX_WORDS))
                buf_err_ff <= 1'b1;
            else
                // one extra count: the arming write itself carries the buffer command
                words_ff <= hwdata[15:6] + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    fcd_pin_engine u_engine (
        .hclk(hclk),
        .hresetn(hresetn),
        .pif(pif),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_addr(flash_addr),
        .flash_dq_in(flash_dq_in),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe)
    );

    chk_setup_status: assert property (@(posedge hclk) disable iff (!hresetn)
        req_wr_ff && setup_ff && !rst_ff |=> mode_ff == MD_STATUS)
        else $error("no status mode after confirm");
    chk_array_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
        req_wr_ff && !setup_ff && words_ff == 10'h000 && !rst_ff
        && cmd == fcd_pkg::CMD_READ_ARRAY |=> mode_ff == MD_ARRAY)
        else $error("array mode not entered");
    chk_rst_array: assert property (@(posedge hclk) disable iff (!hresetn)
        rst_ff |=> mode_ff == MD_ARRAY) else $error("reset left mode");
    chk_pin_rst: assert property (@(posedge hclk) disable iff (!hresetn)
        rst_ff |-> !reset_powerdown_n && !req_wr_ff) else $error("write in reset");
    chk_write_reaches: assert property (@(posedge hclk) disable iff (!hresetn)
        req_wr_ff |-> ##[1:4] !flash_we_n) else $error("write strobe missing");
endmodule // fcd_host

// ===== bench/fcd_flash_model.sv
// flash device model answering the host controller pins
`timescale 1ns/100ps
module fcd_flash_model #(
    parameter int OP_NS = 30000,
    parameter logic [15:0] ID_CODE = 16'h5a5a, // arbitrary value
    parameter logic [7:0] QRY_CODE = 8'h33 // arbitrary value
) (
    // control pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_powerdown_n,
    // address and data
    input wire logic [23:0] addr,
    input wire logic [15:0] din,
    input wire logic din_en,
    output logic [15:0] dout
);
    logic [15:0] mem [logic [23:0]];
    logic [23:0] bq_a [$];
    logic [15:0] bq_d [$];
    logic [23:0] kq [$];
    logic [1:0] mode = 2'd0;
    logic [1:0] setup = 2'd0;
    logic [7:0] sw = 8'h80;
    logic [7:0] sw_seen = 8'h80;
    logic busy = 1'b0;
    logic susp = 1'b0;
    logic is_erase = 1'b0;
    logic [15:0] rdv;
    int rem;
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] arr(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    task automatic command(input logic [15:0] d);
        if (busy && !susp)
        begin
            if (d[7:0] == 8'h70)
                mode = 2'd1;
            if (d[7:0] == 8'hB0)
            begin
                susp = 1'b1;
                sw[7] = 1'b1;
                sw[is_erase ? 6 : 2] = 1'b1;
            end
        end
        else if (setup == 2'd3 && d != 16'h00D0)
        begin
            bq_a.push_back(addr);
            bq_d.push_back(d);
        end
        else if (setup != 2'd0)
        begin
            mode = 2'd1;
            if (setup == 2'd2 && d[7:0] != 8'hD0)
                sw[5:4] = 2'b11;
            else
            begin
                if (setup == 2'd1)
                    mem[addr] = arr(addr) & d;
                kq.delete();
                if (setup == 2'd2)
                    foreach (mem[k])
                        if (k[23:16] == addr[23:16])
                            kq.push_back(k);
                foreach (kq[i])
                    mem.delete(kq[i]);
                while (bq_a.size() > 0)
                    mem[bq_a.pop_front()] = bq_d.pop_front();
                is_erase = (setup == 2'd2);
                busy = 1'b1;
                sw[7] = 1'b0;
                rem = OP_NS / 100;
            end
            setup = 2'd0;
        end
        else if (susp && d[7:0] == 8'hD0)
        begin
            susp = 1'b0;
            sw[7] = 1'b0;
            sw[6] = 1'b0;
            sw[2] = 1'b0;
        end
        else
            case (d[7:0])
                8'hFF: mode = 2'd0;
                8'h70: mode = 2'd1;
                8'h90: mode = 2'd2;
                8'h98: mode = 2'd3;
                8'h50: sw[5:4] = 2'b00;
                8'h40: setup = 2'd1;
                8'h20: setup = 2'd2;
                8'hE8: setup = 2'd3;
                default: ;
            endcase
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge reset_powerdown_n or posedge we_n)
        if (!reset_powerdown_n)
        begin
            mode = 2'd0;
            setup = 2'd0;
            sw = 8'h80;
            busy = 1'b0;
            susp = 1'b0;
        end
        else if (!ce_n && din_en)
            command(din);
    // internal sequencer time base, unrelated to the host clock
    always #100
        if (busy && !susp && reset_powerdown_n)
        begin
            rem--;
            if (rem <= 0)
            begin
                busy = 1'b0;
                sw[7] = 1'b1;
            end
        end
    always @(negedge ce_n or negedge oe_n)
        sw_seen = sw;
    always @*
        case (mode)
            2'd0: rdv = arr(addr);
            2'd1: rdv = {8'h00, sw_seen};
            2'd2: rdv = ID_CODE;
            default: rdv = {8'h00, QRY_CODE};
        endcase
    // released bus shows the inverse so stale data never matches
    assign dout = (!ce_n && !oe_n && reset_powerdown_n) ? rdv : ~rdv;
endmodule // fcd_flash_model

// ===== bench/tb_top.sv
// self-checking bench for the host flash command controller
`timescale 1ns/100ps
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, res_val;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ce_n, oe_n, we_n, dq_oe, reset_powerdown_n;
    logic [23:0] faddr;
    logic [15:0] dq_in, dq_out;
    logic [31:0] exp_q [$];
    string name_q [$];
    event res_ev;
    int err_total = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////
    fcd_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
        .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .reset_powerdown_n(reset_powerdown_n));
    fcd_flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_powerdown_n(reset_powerdown_n),
        .addr(faddr), .din(dq_out), .din_en(dq_oe), .dout(dq_in));
    initial
    begin
        hclk = 1'b0;
        forever
            #50 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, off};
        hwrite <= wr;
        do
            @(posedge hclk);
        while (!hreadyout);
        htrans <= 2'b00;
        hwdata <= d;
        do
            @(posedge hclk);
        while (!hreadyout);
        r = hrdata;
    endtask
    task automatic rw(input logic [3:0] off, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, {4'h0, off}, d, r);
    endtask
    task automatic rr(input logic [3:0] off, output logic [31:0] r);
        ahb(1'b0, {4'h0, off}, 32'h0000_0000, r);
    endtask
    task automatic note(input string nm, input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        name_q.push_back(nm);
        res_val = g;
        ->res_ev;
        #1;
    endtask
    task automatic wait_idle;
        logic [31:0] r;
        int n;
        n = 0;
        r = 32'h0000_0100;
        while (r[8] && n < 40)
        begin
            rr(fcd_pkg::REG_STAT, r);
            n++;
        end
        if (r[8])
            note("pin cycle end", 32'h0000_0000, {31'h0, r[8]});
    endtask
    task automatic fcmd(input logic [23:0] a, input logic [15:0] d);
        rw(fcd_pkg::REG_ADDR, {8'h00, a});
        rw(fcd_pkg::REG_WDATA, {16'h0000, d});
        rw(fcd_pkg::REG_CTRL, 32'h0000_0001);
        wait_idle;
    endtask
    task automatic fget(input logic [23:0] a, output logic [15:0] v);
        logic [31:0] r;
        rw(fcd_pkg::REG_ADDR, {8'h00, a});
        rw(fcd_pkg::REG_CTRL, 32'h0000_0002);
        wait_idle;
        rr(fcd_pkg::REG_STAT, r);
        v = r[31:16];
    endtask
    task automatic fchk(input logic [23:0] a, input logic [15:0] e, input string nm);
        logic [15:0] v;
        fget(a, v);
        note(nm, {16'h0000, e}, {16'h0000, v});
    endtask
    // polls status; the sequencer time is the model's, so no fixed wait
    task automatic wait_ready;
        logic [15:0] v;
        int n;
        v = 16'h0000;
        n = 0;
        while (!v[7] && n < 100)
        begin
            fget(24'h00_0000, v);
            n++;
        end
        note("sequencer ready", 32'h0000_0001, {31'h0, v[7]});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(res_ev)
    begin
        logic [31:0] e;
        string nm;
        e = exp_q.pop_front();
        nm = name_q.pop_front();
        n_checks++;
        if (res_val !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, res_val);
        end
    end
    initial
    begin
        #2_000_000;
        err_total++;
        print_verdict;
    end
    initial
    begin
        logic [23:0] a, b;
        logic [15:0] d;
        logic [15:0] bd [3];
        logic [31:0] r;
        logic [7:0] cmd [4];
        logic [15:0] ev [4];
        cmd = '{8'hFF, 8'h70, 8'h90, 8'h98};
        ev = '{16'hFFFF, 16'h0080, 16'h5a5a, 16'h0033};
        hresetn = 1'b0;
        hsel = 1'b1;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        void'($urandom(32'h061408ed));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        a = 24'($urandom);
        d = 16'($urandom);
        b = a ^ 24'h10_0000;
        fchk(a, 16'hFFFF, "array after reset");
        for (int i = 0; i < 4; i++)
        begin
            fcmd(24'($urandom), {8'h00, cmd[i]});
            fchk(a, ev[i], "read mode");
        end
        fcmd(a, 16'h0040);
        fcmd(a, d);
        fchk(a, 16'h0000, "program busy");
        fcmd(a, 16'h00FF);
        fchk(a, 16'h0000, "ignored in program");
        wait_ready;
        fcmd(a, 16'h00FF);
        fchk(a, d, "programmed word");
        fcmd(a, 16'h0020);
        fcmd(a, 16'h00FF);
        fchk(a, 16'h00B0, "sequence error");
        fcmd(a, 16'h0050);
        fchk(a, 16'h0080, "errors cleared");
        fcmd(a, 16'h0020);
        fcmd(a, 16'h00D0);
        fcmd(a, 16'h0090);
        fchk(a, 16'h0000, "erase busy");
        fcmd(24'($urandom), 16'h00B0);
        fchk(a, 16'h00C0, "erase suspend");
        fcmd(24'($urandom), 16'h00D0);
        fchk(a, 16'h0000, "erase resumed");
        wait_ready;
        fcmd(a, 16'h00FF);
        fchk(a, 16'hFFFF, "block erased");
        fcmd(a, 16'h0040);
        fcmd(a ^ 24'h00_0001, d);
        fcmd(a, 16'h00B0);
        fchk(a, 16'h0084, "program suspend");
        fcmd(a, 16'h00FF);
        fcmd(a, 16'h0070);
        fchk(a, 16'h0084, "still suspended");
        rw(fcd_pkg::REG_CTRL, 32'h0000_0004);
        rr(fcd_pkg::REG_CTRL, r);
        note("ctrl readback", 32'h0000_0004, r);
        note("powerdown pin", 32'h0000_0000, {31'h0, reset_powerdown_n});
        rw(fcd_pkg::REG_CTRL, 32'h0000_0000);
        fchk(a, 16'hFFFF, "array after powerdown");
        fcmd(a, 16'h0070);
        fchk(a, 16'h0080, "status after powerdown");
        rw(fcd_pkg::REG_ADDR, {8'h00, b});
        rw(fcd_pkg::REG_WDATA, 32'h0000_00E8);
        rw(fcd_pkg::REG_CTRL, 32'h0000_00C1); // count of 3 in ctrl[15:6]
        wait_idle;
        for (int i = 0; i < 3; i++)
        begin
            bd[i] = 16'h8000 | 16'($urandom);
            fcmd(b + 24'(i), bd[i]);
        end
        rr(fcd_pkg::REG_STAT, r);
        note("confirm due", 32'h0000_0400, r & 32'h0000_0400);
        fcmd(b, 16'h00D0);
        rr(fcd_pkg::REG_STAT, r);
        note("confirm taken", 32'h0000_0000, r & 32'h0000_0400);
        fchk(b, 16'h0000, "buffer busy");
        wait_ready;
        fcmd(b, 16'h00FF);
        for (int i = 0; i < 3; i++)
            fchk(b + 24'(i), bd[i], "buffer word");
        rw(fcd_pkg::REG_WDATA, 32'h0000_0070);
        rw(fcd_pkg::REG_CTRL, 32'h0000_8041); // 513 words
        wait_idle;
        rr(fcd_pkg::REG_STAT, r);
        note("buffer count error", 32'h0000_1000, r & 32'h0000_1000);
        fcmd(b, 16'h0050);
        rr(fcd_pkg::REG_STAT, r);
        note("count error cleared", 32'h0000_0000, r & 32'h0000_1000);
        ahb(1'b0, 8'h10, 32'h0000_0000, r);
        note("unmapped read", 32'h0000_0000, r);
        note("response", 32'h0000_0000, {31'h0, hresp});
        print_verdict;
    end
endmodule // tb_top
